/* File: core/bit_clock_gen.sv */
// bit clock generator: free divider with fall and rise pulses
// assumes enable is a level on clk
`timescale 1ns/1ps
module bit_clock_gen
#(
  parameter int period = 8
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  output logic bit_clk,
  output logic fall_pulse,
  output logic rise_pulse
);
  // half period count
  localparam int half = period / 2;
  logic [7:0] cnt_ff;
  logic clk_ff;
  // divider counter, wraps every half period
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff <= 8'h00;
      clk_ff <= 1'b0;
    end
    else if (!enable)
    begin
      cnt_ff <= 8'h00;
      clk_ff <= 1'b0;
    end
    else if (cnt_ff == 8'(half - 1))
    begin
      cnt_ff <= 8'h00;
      clk_ff <= ~clk_ff;
    end
    else
    begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
  // edge pulses precede the toggle by one cycle
  assign fall_pulse = enable && clk_ff && (cnt_ff == 8'(half - 1));
  assign rise_pulse = enable && !clk_ff && (cnt_ff == 8'(half - 1));
  assign bit_clk = clk_ff;
endmodule : bit_clock_gen

/* File: core/radio_direct_serial_port.sv */
// direct serial port of the radio with its configuration register bank
// assumes avalon-mm master on clk; demod data arrives on clk; io pins external
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module radio_direct_serial_port
  import radio_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic demod_bit,
  input wire logic handler_bit,
  input wire logic handler_valid,
  output logic tx_bit,
  output logic tx_bit_valid,
  input wire logic io0_in,
  output logic io0_out,
  output logic io0_oe,
  input wire logic io1_in,
  output logic io1_out,
  output logic io1_oe,
  output logic variable_length,
  output logic [15:0] fixed_length
);
  import radio_port_pkg::*;

  // register bank
  logic [7:0] regs_ff [reg_count];
  // burst buffer and its fill count
  logic [7:0] burst_ff [burst_max];
  logic [4:0] burst_count_ff;
  // bus answer stage
  logic ack_ff;
  logic [31:0] rdata_ff;
  // io0 synchroniser
  logic io0_s1_ff;
  logic io0_s2_ff;
  // io1 synchroniser, unused as input but kept quiet
  logic io1_s1_ff;
  // current serial bits
  logic rx_out_ff;
  logic tx_bit_ff;
  logic tx_valid_ff;
  // operating state
  op_state_t op_ff;
  // clock generator taps
  logic bit_clk;
  logic fall_pulse;
  logic rise_pulse;
  direct_mode_t mode;
  logic [7:0] ctl;
  logic [7:0] word_idx;
  logic [7:0] wbyte;
  logic hit_write;
  logic access;

  // slot lookup of an index, reg_count when unmapped
  function automatic int find_slot(input logic [7:0] idx);
    int s;
    s = reg_count;
    for (int i = 0; i < reg_count; i++)
    begin
      if (reg_index[i] == idx)
      begin
        s = i;
      end
    end
    return s;
  endfunction : find_slot

  // field views
  assign ctl = regs_ff[slot_direct_ctrl];
  assign mode = direct_mode_t'(ctl[ctl_mode_lo +: 2]);
  assign word_idx = avs_address[9:2];
  assign wbyte = avs_writedata[7:0];
  assign access = avs_read || avs_write;
  // one wait cycle per access, then a single acknowledge
  assign avs_waitrequest = access && !ack_ff;
  assign hit_write = avs_write && !ack_ff && avs_byteenable[0];

  // acknowledge toggles so each access takes exactly two cycles
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ack_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= access && !ack_ff;
    end
  end

  // register bank writes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < reg_count; i++)
      begin
        regs_ff[i] <= reg_reset[i];
      end
    end
    else if (hit_write && find_slot(word_idx) < reg_count)
    begin
      regs_ff[find_slot(word_idx)] <= wbyte;
    end
  end

  // burst snapshot: write to read_count index fills count regs from start
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      burst_count_ff <= 5'h00;
      for (int i = 0; i < burst_max; i++)
      begin
        burst_ff[i] <= 8'h00;
      end
    end
    else if (hit_write && word_idx == idx_read_count)
    begin
      burst_count_ff <= (avs_writedata[15:8] > 8'(burst_max)) ?
        5'(burst_max) : avs_writedata[12:8];
      for (int i = 0; i < burst_max; i++)
      begin
        if (8'(i) < avs_writedata[15:8] && find_slot(wbyte + 8'(i)) < reg_count)
        begin
          burst_ff[i] <= regs_ff[find_slot(wbyte + 8'(i))];
        end
        else
        begin
          burst_ff[i] <= 8'h00;
        end
      end
    end
  end

  // read data mux, unmapped reads zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_ff <= 32'h0000_0000;
    end
    else if (avs_read && !ack_ff)
    begin
      if (find_slot(word_idx) < reg_count)
      begin
        rdata_ff <= {24'h00_0000, regs_ff[find_slot(word_idx)]};
      end
      else if (word_idx == idx_state)
      begin
        rdata_ff <= {30'h0000_0000, op_ff};
      end
      else if (word_idx == idx_version)
      begin
        rdata_ff <= {24'h00_0000, version_default};
      end
      else if (word_idx == idx_read_count)
      begin
        rdata_ff <= {27'h000_0000, burst_count_ff};
      end
      else if (word_idx >= idx_burst_base && word_idx < idx_burst_base + 8'(burst_max))
      begin
        rdata_ff <= {24'h00_0000, burst_ff[4'(word_idx - idx_burst_base)]};
      end
      else
      begin
        rdata_ff <= 32'h0000_0000;
      end
    end
  end
  assign avs_readdata = rdata_ff;

  // operating state from control bits
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      op_ff <= op_ready;
    end
    else if (ctl[ctl_tx_on])
    begin
      op_ff <= op_tx;
    end
    else if (ctl[ctl_rx_on])
    begin
      op_ff <= op_rx;
    end
    else
    begin
      op_ff <= op_ready;
    end
  end

  // bit clock runs only in an active direct mode
  bit_clock_gen #(.period(bit_period_cycles)) u_clk
  (
    .clk(clk),
    .rst(rst),
    .enable((mode == mode_tx && op_ff == op_tx) ||
      ((mode == mode_rx || mode == mode_rx_raw) && op_ff == op_rx)),
    .bit_clk(bit_clk),
    .fall_pulse(fall_pulse),
    .rise_pulse(rise_pulse)
  );

  // pin synchronisers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      io0_s1_ff <= 1'b0;
      io0_s2_ff <= 1'b0;
      io1_s1_ff <= 1'b0;
    end
    else
    begin
      io0_s1_ff <= io0_in;
      io0_s2_ff <= io0_s1_ff;
      io1_s1_ff <= io1_in;
    end
  end

  // rx data changes on rising clock edge, stable at the falling edge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_out_ff <= 1'b0;
    end
    // change on rise, far side samples fall
    else if (rise_pulse)
    begin
      // raw mode takes demod bit directly
      if (mode == mode_rx_raw)
      begin
        rx_out_ff <= demod_bit;
      end
      else if (handler_valid)
      begin
        rx_out_ff <= handler_bit;
      end
    end
  end

  // tx bits sampled at device falling edge, in place of fifo data
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_bit_ff <= 1'b0;
      tx_valid_ff <= 1'b0;
    end
    else if (mode == mode_tx && fall_pulse)
    begin
      tx_bit_ff <= io0_s2_ff;
      tx_valid_ff <= 1'b1;
    end
    else
    begin
      tx_valid_ff <= 1'b0;
    end
  end
  assign tx_bit = tx_bit_ff;
  assign tx_bit_valid = tx_valid_ff;

  // pin drivers
  // data on io0, clock io1
  assign io0_out = rx_out_ff;
  assign io0_oe = (mode == mode_rx || mode == mode_rx_raw) && op_ff == op_rx;
  assign io1_out = bit_clk;
  assign io1_oe = io0_oe || (mode == mode_tx && op_ff == op_tx);

  assign variable_length = regs_ff[slot_frame_control2][ctl_length_mode];
  assign fixed_length = {regs_ff[slot_length_high], regs_ff[slot_length_low]};
endmodule : radio_direct_serial_port

/* File: core/radio_port_pkg.sv */
// package for the direct serial port: register map, reset values, modes
// assumes an 8-bit register space reached over a 32-bit avalon slave
package radio_port_pkg;
  // register map indices (byte address is four times the index)
  localparam int reg_count = 38;
  localparam logic [7:0] reg_index [reg_count] = '{
    8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A,
    8'h0B, 8'h0C, 8'h0D, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16,
    8'h17, 8'h18, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h21, 8'h22, 8'h23,
    8'h26, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36};
  // reset values, same order as the map; last slot is the direct port control
  localparam logic [7:0] reg_reset [reg_count] = '{
    8'hC0, 8'hA2, 8'hA2, 8'hA2, 8'h0A, 8'h00, 8'hA3, 8'h0C, 8'h84, 8'hEC,
    8'h51, 8'hFC, 8'hA3, 8'h03, 8'h0E, 8'h1A, 8'h25, 8'h35, 8'h40, 8'h4E,
    8'h00, 8'h07, 8'h83, 8'h07, 8'h45, 8'h23, 8'hC8, 8'hE3, 8'h24, 8'h58,
    8'h8A, 8'h00, 8'h00, 8'h1E, 8'h20, 8'h00, 8'h14, 8'h00};
  // slot positions used by the logic
  localparam int slot_frame_control2 = 33;
  localparam int slot_length_high = 35;
  localparam int slot_length_low = 36;
  localparam int slot_direct_ctrl = 37;
  // indices of my own; state and version are read-only, a write to read_count starts a burst
  localparam logic [7:0] idx_state = 8'h40;
  localparam logic [7:0] idx_version = 8'h41;
  localparam logic [7:0] idx_read_count = 8'h42;
  // burst window: indices from this base read the burst buffer
  localparam logic [7:0] idx_burst_base = 8'h80;
  localparam int burst_max = 16;
  // direct control fields, and the length mode bit of frame control2
  localparam int ctl_mode_lo = 0;
  localparam int ctl_rx_on = 2;
  localparam int ctl_tx_on = 3;
  localparam int ctl_length_mode = 0;
  // version value is arbitrary
  localparam logic [7:0] version_default = 8'h5A;
  // bit clock period in cycles of clk
  localparam int bit_period_cycles = 8;
  // direct modes
  typedef enum logic [1:0] {mode_off, mode_rx, mode_tx, mode_rx_raw} direct_mode_t;
  // operating states
  typedef enum logic [1:0] {op_ready, op_rx, op_tx} op_state_t;
endpackage : radio_port_pkg

/* File: tb/bit_tester_model.sv */
// far side model: a bit tester on the two io pins
// assumes io1 is the device clock, driven only in direct modes
`timescale 1ns/1ps
module bit_tester_model
(
  input wire logic clk,
  input wire logic io0_out,
  input wire logic io0_oe,
  input wire logic io1_out,
  input wire logic io1_oe,
  output logic io0_in,
  output logic io1_in,
  output logic [7:0] rx_shift = 8'h00
);
  logic drv_bit = 1'b0; // bit presented on io0
  logic [2:0] pos = 3'h0; // place in tx pattern
  logic prev = 1'b0; // io1 one clk ago
  // wire levels; undriven lines keep moving
  assign io0_in = io0_oe ? io0_out : drv_bit;
  assign io1_in = io1_oe ? io1_out : clk;
  always @(negedge io1_out)
    if (io0_oe) rx_shift <= {rx_shift[6:0], io0_out};
  always @(posedge clk)
  begin
    prev <= io1_out;
    if (!(io1_oe && !io0_oe))
      drv_bit <= ~drv_bit;
    else if (io1_out && !prev)
    begin
      drv_bit <= pos[0] ^ pos[2];
      pos <= pos + 3'h1;
    end
  end
endmodule : bit_tester_model

/* File: tb/port_checker_properties.sv */
// checker of the direct port bus handshake and pins
// assumes it is bound onto the port top module
`timescale 1ns/1ps
module port_checker
(
  input wire logic clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic io0_out,
  input wire logic io0_oe,
  input wire logic io1_out,
  input wire logic io1_oe,
  input wire logic tx_bit_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  one_wait_a: assert property (
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("wait cycle count wrong");
  read_hold_a: assert property (
    !avs_read |=> $stable(avs_readdata)) else $error("read data moved");
  upper_zero_a: assert property (
    avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
  data_clock_a: assert property (
    io0_oe |-> io1_oe) else $error("data driven without clock");
  clock_fall_a: assert property (
    $rose(io1_out) |-> ##[1:7] $fell(io1_out)) else $error("bit clock stuck");
  fall_stable_a: assert property (
    $fell(io1_out) && io0_oe |-> $stable(io0_out)) else $error("data moved at fall");
  tx_pins_a: assert property (
    tx_bit_valid |-> io1_oe && !io0_oe) else $error("tx pin directions wrong");
  tx_pulse_a: assert property (
    tx_bit_valid |=> !tx_bit_valid) else $error("tx valid too long");
endmodule : port_checker

bind radio_direct_serial_port port_checker i_chk (.clk, .rst, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .io0_out, .io0_oe, .io1_out, .io1_oe, .tx_bit_valid);

/* File: tb/tb_radio_direct_serial_port.sv */
// bench for the direct serial port: register bus, direct modes
// assumes the checker binds itself from its own file
`timescale 1ns/1ps
module tb_radio_direct_serial_port;
  import radio_port_pkg::*;
  logic clk = 1'b0; // 40 MHz
  logic rst = 1'b1;
  logic [9:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic demod_bit = 1'b0;
  logic handler_bit = 1'b0;
  logic handler_valid = 1'b1;
  logic tx_bit, tx_bit_valid, io0_in, io0_out, io0_oe, io1_in, io1_out, io1_oe;
  logic variable_length;
  logic [15:0] fixed_length;
  logic [7:0] rx_shift; // bits seen by far side
  logic [31:0] q; // last read word
  int failures = 0;
  int tests_run = 0;
  always #12.5 clk = ~clk;
  radio_direct_serial_port i_dut (.clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .demod_bit,
    .handler_bit, .handler_valid, .tx_bit, .tx_bit_valid, .io0_in, .io0_out, .io0_oe,
    .io1_in, .io1_out, .io1_oe, .variable_length, .fixed_length);
  bit_tester_model i_far (.clk, .io0_out, .io0_oe, .io1_out, .io1_oe, .io0_in,
    .io1_in, .rx_shift);
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
      $display("Error %0t: got %h want %h", $time, got, exp);
    if (got !== exp)
      failures++;
  endtask : chk
  // one transfer, held until waitrequest is low at an edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // waitrequest and read data are taken at the rising edge itself
    do
    begin
      @(posedge clk);
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(q, exp);
  endtask : rd_chk
  // defaults, version, state, hole
  task automatic t_defaults;
    for (int i = 0; i < reg_count; i++)
      rd_chk(reg_index[i], {24'h0, reg_reset[i]});
    rd_chk(idx_version, {24'h0, version_default});
    rd_chk(idx_state, 32'h0);
    rd_chk(8'h0E, 32'h0);
  endtask : t_defaults
  // one write, refused writes, burst of four
  task automatic t_write;
    bus(1'b1, 8'h0C, 32'h3C);
    avs_byteenable <= 4'hE;
    bus(1'b1, 8'h0C, 32'h77);
    avs_byteenable <= 4'hF;
    bus(1'b1, 8'h0E, 32'h55);
    rd_chk(8'h0B, 32'h51);
    rd_chk(8'h0C, 32'h3C);
    rd_chk(8'h0E, 32'h0);
    bus(1'b1, idx_read_count, 32'h0407);
    rd_chk(idx_read_count, 32'h4);
    rd_chk(idx_burst_base, 32'hA3);
    rd_chk(idx_burst_base + 8'h3, 32'hEC);
  endtask : t_write
  // length mode and fixed length outputs
  task automatic t_length;
    chk({31'h0, variable_length}, 32'h0);
    bus(1'b1, 8'h32, 32'h1F);
    bus(1'b1, 8'h34, 32'h01);
    repeat (2) @(posedge clk);
    chk({15'h0, fixed_length, variable_length}, 32'h229);
  endtask : t_length
  // receive direct modes, raw and via handler
  task automatic t_rx(input logic [7:0] ctl, input logic d, input logic h,
                      input logic [7:0] exp);
    bus(1'b1, 8'h36, {24'h0, ctl});
    demod_bit <= d;
    handler_bit <= h;
    repeat (12 * bit_period_cycles) @(posedge clk);
    chk({22'h0, rx_shift, io1_oe, io0_oe}, {22'h0, exp, 2'b11});
    rd_chk(idx_state, 32'h1);
  endtask : t_rx
  // transmit direct mode, far side supplies bits
  task automatic t_tx;
    int n;
    bus(1'b1, 8'h36, 32'h0A);
    for (int k = 0; k < 8; k++)
    begin
      n = 0;
      do
      begin
        @(negedge clk);
        n++;
      end
      while (tx_bit_valid !== 1'b1 && n < 40);
      chk({tx_bit_valid, tx_bit}, {1'b1, io0_in});
    end
    rd_chk(idx_state, 32'h2);
    bus(1'b1, 8'h36, 32'h00);
    rd_chk(idx_state, 32'h0);
  endtask : t_tx
  task automatic end_sim;
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_defaults();
    t_write();
    t_length();
    t_rx(8'h07, 1'b1, 1'b0, 8'hFF);
    t_rx(8'h05, 1'b1, 1'b0, 8'h00);
    t_rx(8'h05, 1'b0, 1'b1, 8'hFF);
    t_tx();
    end_sim();
  end
  initial
  begin
    #200000;
    failures++;
    end_sim();
  end
endmodule : tb_radio_direct_serial_port
